//--- nvsram_chk.sv
// Checker for the controller's device pins.
`timescale 1ns/1ns
`include "nvsram_ctrl_consts.vh"
module nvsram_chk
#(parameter SAVE_CYCLES = 1, LOAD_CYCLES = 1, POWERUP_CYCLES = 1)
(
  // Clock, reset and command port.
  input wire        sys_clk,
  input wire        rst_n,
  input wire        cmd_valid,
  input wire [1:0]  cmd_op,
  input wire        cmd_ready,
  input wire        rsp_valid,
  input wire        cmd_error,
  input wire        supply_ok,
  // Device pins.
  input wire        cs_n,
  input wire        oe_n,
  input wire        wr_strobe_n,
  input wire [14:0] addr,
  input wire        io_bus_oe
);
  reg  up_q;
  reg  nv_q;
  wire take = cmd_valid && cmd_ready;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Power-up ends at the first ready; nv_q marks a sequence in flight.
  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      up_q <= 1'b0;
      nv_q <= 1'b0;
    end
    else
    begin
      up_q <= up_q | cmd_ready;
      nv_q <= take ? cmd_op[1] : (nv_q & ~rsp_valid);
    end
  sequence first_rd;
    !cs_n && wr_strobe_n && addr[13:0] == `SEQ_ADDR0;
  endsequence
  sequence save_rd;
    !cs_n && wr_strobe_n && addr[13:0] == `SEQ_SAVE_ADDR;
  endsequence
  sequence load_rd;
    !cs_n && wr_strobe_n && addr[13:0] == `SEQ_LOAD_ADDR;
  endsequence
  a_wr_addr_hold: assert property (
    !cs_n && !wr_strobe_n |=> cs_n || wr_strobe_n || $stable(addr))
    else $error("address moved in write");
  a_oe_off_wr: assert property (
    !wr_strobe_n || io_bus_oe |-> oe_n) else $error("oe low in write");
  a_quiet_power: assert property (
    !up_q |-> cs_n && wr_strobe_n) else $error("strobe in power-up");
  a_save_first: assert property (
    take && cmd_op == `CMD_SAVE && supply_ok |-> ##[1:10] first_rd)
    else $error("save sequence start");
  a_save_last: assert property (
    take && cmd_op == `CMD_SAVE && supply_ok |-> ##[1:300] save_rd)
    else $error("save sequence end");
  a_load_last: assert property (
    take && cmd_op == `CMD_LOAD |-> ##[1:300] load_rd)
    else $error("load sequence end");
  a_seq_reads: assert property (
    nv_q |-> wr_strobe_n && !io_bus_oe) else $error("write in sequence");
  a_seq_low_bank: assert property (
    nv_q && !cs_n |-> !addr[14]) else $error("sequence bank bit");
  a_save_refused: assert property (
    take && cmd_op == `CMD_SAVE && !supply_ok |=> cmd_error && rsp_valid)
    else $error("save not refused");
  a_refuse_quiet: assert property (
    take && cmd_op == `CMD_SAVE && !supply_ok |=> cs_n [*8])
    else $error("strobe after refused save");
endmodule // nvsram_chk
bind nvsram_ctrl nvsram_chk #(.SAVE_CYCLES(SAVE_CYCLES),
  .LOAD_CYCLES(LOAD_CYCLES), .POWERUP_CYCLES(POWERUP_CYCLES)) chk_i (.*);

//--- nvsram_ctrl.v
// Host controller that drives the nonvolatile SRAM pins.
`timescale 1ns/1ns
`include "nvsram_ctrl_consts.vh"
// Summary of operation
// - Address held stable across whole write
// - Output enable kept high during writes
// - Six read sequence ending 0FC0 starts save
// - Sequence reads framed by chip select pulses
// - Six read sequence ending 0C63 starts load
// - Strobes inactive until power-up load ends
// - Write strobe high during all six reads
module nvsram_ctrl
#(
  parameter SAVE_CYCLES    = `SAVE_CYC,
  parameter LOAD_CYCLES    = `LOAD_CYC,
  parameter POWERUP_CYCLES = `POWERUP_CYC
)
(
  // Clock and reset.
  input  wire        sys_clk,
  input  wire        rst_n,
  // Supply monitor: high while supply is above supply_trip_level.
  input  wire        supply_ok,
  // User command port.
  input  wire        cmd_valid,
  input  wire [1:0]  cmd_op,
  input  wire [14:0] cmd_addr,
  input  wire [7:0]  cmd_wdata,
  output reg         cmd_ready,
  output reg         rsp_valid,
  output reg  [7:0]  rsp_rdata,
  output reg         cmd_error,
  // Device pins.
  output reg         cs_n,
  output reg         oe_n,
  output reg         wr_strobe_n,
  output reg  [14:0] addr,
  output reg  [7:0]  io_bus_o,
  output reg         io_bus_oe,
  input  wire [7:0]  io_bus_i
);
  localparam ST_PWRUP = 3'h0;
  localparam ST_IDLE  = 3'h1;
  localparam ST_SETUP = 3'h2;
  localparam ST_PULSE = 3'h3;
  localparam ST_RECOV = 3'h4;
  localparam ST_BUSY  = 3'h5;
  // Phase counts held at full width so the phase load cuts them on purpose.
  localparam [31:0] SETUP_LEN = `SETUP_CYC;
  localparam [31:0] PULSE_LEN = `PULSE_CYC;
  localparam [31:0] RECOV_LEN = `RECOVER_CYC;

  reg  [2:0]  state_q;
  reg  [1:0]  op_q;
  reg  [2:0]  seq_idx_q;
  reg  [7:0]  phase_q;
  reg         supply_ok_q;
  reg         tmr_load;
  reg  [31:0] tmr_count;
  reg  [13:0] seq_addr;
  wire        tmr_done;
  wire        is_seq;
  wire        last_step;

  // Timer shared by power-up, save and load waits.
  nvsram_wait_timer u_timer
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .load    (tmr_load),
    .count   (tmr_count),
    .done    (tmr_done)
  );

  // Address of the step after the current one; the last picks save or load.
  always @*
  begin
    case (seq_idx_q)
      3'h0:    seq_addr = `SEQ_ADDR1;
      3'h1:    seq_addr = `SEQ_ADDR2;
      3'h2:    seq_addr = `SEQ_ADDR3;
      3'h3:    seq_addr = `SEQ_ADDR4;
      default: seq_addr = (op_q == `CMD_SAVE) ? `SEQ_SAVE_ADDR
                                              : `SEQ_LOAD_ADDR;
    endcase
  end

  assign is_seq    = op_q[1];
  assign last_step = (seq_idx_q == 3'h5);

  // Timer loads on power-up detection or at the end of the sixth read.
  always @*
  begin
    tmr_load  = 1'b0;
    tmr_count = 32'h00000000;
    if (state_q == ST_PWRUP && !supply_ok_q)
    begin
      tmr_load  = 1'b1;
      tmr_count = POWERUP_CYCLES;
    end
    else if (state_q == ST_PULSE && phase_q == 8'h00 && is_seq && last_step)
    begin
      tmr_load  = 1'b1;
      tmr_count = (op_q == `CMD_SAVE) ? SAVE_CYCLES : LOAD_CYCLES;
    end
  end

  // Main strobe sequencer.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= ST_PWRUP;
      op_q        <= `CMD_READ;
      seq_idx_q   <= 3'h0;
      phase_q     <= 8'h00;
      supply_ok_q <= 1'b0;
      cmd_ready   <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_rdata   <= 8'h00;
      cmd_error   <= 1'b0;
      cs_n        <= 1'b1;
      oe_n        <= 1'b1;
      wr_strobe_n <= 1'b1;
      addr        <= 15'h0000;
      io_bus_o    <= 8'h00;
      io_bus_oe   <= 1'b0;
    end
    else
    begin
      supply_ok_q <= supply_ok;
      rsp_valid   <= 1'b0;
      cmd_error   <= 1'b0;
      case (state_q)
        // Strobes stay high until the supply is good and recall ends.
        ST_PWRUP:
        begin
          cs_n        <= 1'b1;
          wr_strobe_n <= 1'b1;
          if (supply_ok_q && tmr_done)
          begin
            state_q   <= ST_IDLE;
            cmd_ready <= 1'b1;
          end
        end
        ST_IDLE:
        begin
          if (!supply_ok_q)
          begin
            // Supply dropped: the device latches a new recall.
            state_q   <= ST_PWRUP;
            cmd_ready <= 1'b0;
          end
          else if (cmd_valid)
          begin
            cmd_ready <= 1'b0;
            op_q      <= cmd_op;
            seq_idx_q <= 3'h0;
            // The raw pin is used so a drop seen this very cycle refuses.
            if (cmd_op == `CMD_SAVE && !supply_ok)
            begin
              cmd_error <= 1'b1;
              rsp_valid <= 1'b1;
              cmd_ready <= 1'b1;
            end
            else
            begin
              state_q <= ST_SETUP;
              phase_q <= SETUP_LEN[7:0];
              if (cmd_op[1])
                addr <= {1'b0, `SEQ_ADDR0};
              else
                addr <= cmd_addr;
              // Write data driven only with the output enable kept high.
              io_bus_o  <= cmd_wdata;
              io_bus_oe <= (cmd_op == `CMD_WRITE);
              oe_n      <= 1'b1;
            end
          end
        end
        // Address settles before the strobes fall.
        ST_SETUP:
        begin
          if (phase_q != 8'h00)
            phase_q <= phase_q - 8'h01;
          else
          begin
            state_q <= ST_PULSE;
            phase_q <= PULSE_LEN[7:0];
            cs_n    <= 1'b0;
            if (op_q == `CMD_WRITE)
              wr_strobe_n <= 1'b0;
            else
            begin
              wr_strobe_n <= 1'b1;
              oe_n        <= is_seq;
            end
          end
        end
        ST_PULSE:
        begin
          if (phase_q != 8'h00)
            phase_q <= phase_q - 8'h01;
          else
          begin
            // Read data sampled before the strobes rise.
            if (op_q == `CMD_READ)
              rsp_rdata <= io_bus_i;
            cs_n        <= 1'b1;
            wr_strobe_n <= 1'b1;
            oe_n        <= 1'b1;
            state_q     <= ST_RECOV;
            phase_q     <= RECOV_LEN[7:0];
          end
        end
        // Address and data held past the rising edge, then next step.
        ST_RECOV:
        begin
          if (phase_q != 8'h00)
            phase_q <= phase_q - 8'h01;
          else
          begin
            io_bus_oe <= 1'b0;
            if (is_seq && last_step)
              state_q <= ST_BUSY;
            else if (is_seq)
            begin
              // Back-to-back reads only, so the sequence is never aborted.
              seq_idx_q <= seq_idx_q + 3'h1;
              addr      <= {1'b0, seq_addr};
              state_q   <= ST_SETUP;
              phase_q   <= SETUP_LEN[7:0];
            end
            else
            begin
              rsp_valid <= 1'b1;
              cmd_ready <= 1'b1;
              state_q   <= ST_IDLE;
            end
          end
        end
        // Device ignores pins; keep strobes high, bus released.
        ST_BUSY:
        begin
          cs_n        <= 1'b1;
          wr_strobe_n <= 1'b1;
          io_bus_oe   <= 1'b0;
          if (tmr_done)
          begin
            rsp_valid <= 1'b1;
            cmd_ready <= 1'b1;
            state_q   <= ST_IDLE;
          end
        end
        default:
          state_q <= ST_PWRUP;
      endcase
    end
  end

endmodule // nvsram_ctrl

//--- nvsram_ctrl_consts.vh
// Constants for the nonvolatile SRAM host controller.
`ifndef NVSRAM_CTRL_CONSTS_VH
`define NVSRAM_CTRL_CONSTS_VH
`define CLK_PERIOD_NS      4
`define ADDR_W             15
`define DATA_W             8
`define SEQ_ADDR0          14'h0E38
`define SEQ_ADDR1          14'h31C7
`define SEQ_ADDR2          14'h03E0
`define SEQ_ADDR3          14'h3C1F
`define SEQ_ADDR4          14'h303F
`define SEQ_SAVE_ADDR      14'h0FC0
`define SEQ_LOAD_ADDR      14'h0C63
`define CMD_READ           2'h0
`define CMD_WRITE          2'h1
`define CMD_SAVE           2'h2
`define CMD_LOAD           2'h3
// Strobe phase timing: setup, low pulse and recovery, in ns.
`define SETUP_NS           8
`define PULSE_NS           48
`define RECOVER_NS         12
`define SETUP_CYC          ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CYC          ((`PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_CYC        ((`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Busy waits after nonvolatile operations, in us.
`define SAVE_US            10000
`define LOAD_US            20
`define POWERUP_US         550
`define SAVE_CYC           ((`SAVE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOAD_CYC           ((`LOAD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERUP_CYC        ((`POWERUP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- nvsram_ctrl_tb.sv
// Self-checking bench for the nvSRAM host controller.
`timescale 1ns/1ns
`include "nvsram_ctrl_consts.vh"
module nvsram_ctrl_tb;
  reg         sys_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         supply_ok = 1'b0;
  reg         cmd_valid = 1'b0;
  reg  [1:0]  cmd_op = 2'h0;
  reg  [14:0] cmd_addr = 15'h0000;
  reg  [7:0]  cmd_wdata = 8'h00;
  reg  [7:0]  last_q = 8'h00;
  reg         drop_supply = 1'b0;
  wire        cmd_ready, rsp_valid, cmd_error, cs_n, oe_n, wr_strobe_n;
  wire        io_bus_oe, drv;
  wire [14:0] addr;
  wire [7:0]  rsp_rdata, io_bus_o, io_bus_i, dout;
  integer     err_count = 0;
  integer     n_checks = 0;
  integer     cyc = 0;
  integer     seed = 44427;
  integer     k;
  reg  [31:0] r;
  reg  [7:0]  mir [0:31];
  reg  [7:0]  sh [0:31];
  reg  [14:0] at [0:31];
  nvsram_ctrl #(.SAVE_CYCLES(20), .LOAD_CYCLES(10), .POWERUP_CYCLES(10))
    nvsram_ctrl_i (.*);
  nvsram_dev nvsram_dev_i (.*, .din(io_bus_i));
  // A released bus shows the inverse of its last value, not a held one.
  assign io_bus_i = io_bus_oe ? io_bus_o : (drv ? dout : ~last_q);
  always #2 sys_clk = ~sys_clk;
  // Cycle ceiling cuts a hang short.
  always @(posedge sys_clk)
  begin
    last_q <= io_bus_i;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count = err_count + 1;
      end_of_test;
    end
  end
  function [7:0] want(input integer j);
    want = mir[j];
  endfunction
  task check(input [7:0] got, input [7:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("MISMATCH %0t read %h want %h", $time, got, exp);
    end
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // One command: wait ready, present it for one edge, wait for the answer.
  task run(input [1:0] op, input [14:0] a, input [7:0] d);
    integer n;
  begin
    n = 0;
    while (cmd_ready !== 1'b1 && n < 500)
    begin
      @(negedge sys_clk);
      n = n + 1;
    end
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    // Optionally pull the supply down on the edge the command is presented, so it is already low at the edge it is taken.
    if (drop_supply)
      supply_ok <= 1'b0;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    @(negedge sys_clk);
    while (rsp_valid !== 1'b1 && n < 500)
    begin
      @(negedge sys_clk);
      n = n + 1;
    end
    if (n >= 500)
    begin
      err_count = err_count + 1;
      end_of_test;
    end
  end
  endtask
  initial
  begin
    for (k = 0; k < 32; k = k + 1)
    begin
      r = $random(seed);
      at[k] = {r[9:0], k[4:0]};
      mir[k] = r[17:10];
    end
    at[1] = at[0] ^ 15'h4000;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    supply_ok <= 1'b1;
    // Power-up load from a blank shadow reads back zero.
    run(`CMD_READ, at[5], 8'h00);
    check(rsp_rdata, 8'h00);
    $display("test power-up done");
    // Random writes, then read back in reverse order.
    for (k = 0; k < 32; k = k + 1)
      run(`CMD_WRITE, at[k], mir[k]);
    for (k = 31; k >= 0; k = k - 1)
    begin
      run(`CMD_READ, at[k], 8'h00);
      check(rsp_rdata, want(k));
    end
    $display("test write read done");
    // Save, overwrite everything, then load the saved image back.
    run(`CMD_SAVE, 15'h0000, 8'h00);
    check({7'h00, cmd_error}, 8'h00);
    for (k = 0; k < 32; k = k + 1)
    begin
      sh[k] = mir[k];
      mir[k] = ~mir[k];
      run(`CMD_WRITE, at[k], mir[k]);
    end
    run(`CMD_READ, at[3], 8'h00);
    check(rsp_rdata, want(3));
    run(`CMD_LOAD, 15'h0000, 8'h00);
    for (k = 0; k < 32; k = k + 1)
    begin
      mir[k] = sh[k];
      run(`CMD_READ, at[k], 8'h00);
      check(rsp_rdata, want(k));
    end
    $display("test save load done");
    // Save refused as the supply drops; the write is undone by the power-up load.
    run(`CMD_WRITE, at[7], ~want(7));
    drop_supply = 1'b1;
    run(`CMD_SAVE, 15'h0000, 8'h00);
    drop_supply = 1'b0;
    check({7'h00, cmd_error}, 8'h01);
    repeat (4) @(posedge sys_clk);
    supply_ok <= 1'b1;
    run(`CMD_READ, at[7], 8'h00);
    check(rsp_rdata, want(7));
    $display("test supply drop done");
    end_of_test;
  end
endmodule // nvsram_ctrl_tb

//--- nvsram_dev.sv
// Behavioural model of the nonvolatile SRAM at its pins.
`timescale 1ns/1ns
`include "nvsram_ctrl_consts.vh"
module nvsram_dev
#(parameter SAVE_NS = 60, LOAD_NS = 30, PWR_NS = 30)
(
  // Strobes, address and supply.
  input  wire        cs_n,
  input  wire        oe_n,
  input  wire        wr_strobe_n,
  input  wire [14:0] addr,
  input  wire        supply_ok,
  // Data bus.
  input  wire [7:0]  din,
  output wire [7:0]  dout,
  output wire        drv
);
  localparam [69:0] SEQ = {`SEQ_ADDR4, `SEQ_ADDR3, `SEQ_ADDR2,
                           `SEQ_ADDR1, `SEQ_ADDR0};
  reg     [7:0] mem [0:32767];
  reg     [7:0] nv [0:32767];
  reg           busy = 1'b1;
  reg           wact = 1'b0;
  reg     [2:0] step = 3'h0;
  integer       i;
  wire   [13:0] a = addr[13:0];
  // Drive only in a read; a write or busy state floats the bus.
  assign drv  = !cs_n && !oe_n && wr_strobe_n && !busy;
  assign dout = mem[addr];
  initial
    for (i = 0; i < 32768; i = i + 1)
      nv[i] = 8'h00;
  // Latched power-up load runs once the supply comes back.
  always @(posedge supply_ok)
  begin
    busy = 1'b1;
    for (i = 0; i < 32768; i = i + 1)
      mem[i] = nv[i];
    #PWR_NS busy = 1'b0;
  end
  // A write lasts while both are low; data is taken as either rises.
  always @(cs_n or wr_strobe_n)
    if (!cs_n && !wr_strobe_n && !busy)
      wact = 1'b1;
    else if (wact)
    begin
      mem[addr] = din;
      wact = 1'b0;
      step = 3'h0;
    end
  // Sequence detector clocked by select-framed reads.
  always @(posedge cs_n)
    if (wr_strobe_n && !busy)
    begin
      if (step == 3'h5 && a == `SEQ_SAVE_ADDR && supply_ok)
      begin
        busy = 1'b1;
        step = 3'h0;
        for (i = 0; i < 32768; i = i + 1)
          nv[i] = mem[i];
        #SAVE_NS busy = 1'b0;
      end
      else if (step == 3'h5 && a == `SEQ_LOAD_ADDR)
      begin
        busy = 1'b1;
        step = 3'h0;
        for (i = 0; i < 32768; i = i + 1)
          mem[i] = nv[i];
        #LOAD_NS busy = 1'b0;
      end
      else if (step < 3'h5 && a == SEQ[step * 14 +: 14])
        step = step + 3'h1;
      else
        step = {2'h0, a == `SEQ_ADDR0};
    end
endmodule // nvsram_dev

//--- nvsram_wait_timer.v
// Loadable down counter that times busy intervals.
`timescale 1ns/1ns
module nvsram_wait_timer
(
  // Clock and reset.
  input  wire        sys_clk,
  input  wire        rst_n,
  // Control.
  input  wire        load,
  input  wire [31:0] count,
  // Status.
  output wire        done
);
  reg [31:0] cnt_q;

  // Counts down to zero after a load; idle at zero.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 32'h00000000;
    else if (load)
      cnt_q <= count;
    else if (cnt_q != 32'h00000000)
      cnt_q <= cnt_q - 32'h00000001;
  end

  assign done = (cnt_q == 32'h00000000) && !load;
endmodule // nvsram_wait_timer
